// File: logic/bdcs_pkg.sv
// Constants shared by the backplane DAC command store.
// Assumes a 100 MHz logic clock.
package bdcs_pkg;
    localparam int CLK_MHZ = 100;
    localparam int DAC_W = 7;
    localparam logic [6:0] SLAVE_ADDR = 7'h2F;
    localparam logic [7:0] CMD_DEC = 8'h00;
    localparam logic [7:0] CMD_INC = 8'hFF;
    localparam logic [7:0] CMD_STORE = 8'hAA;
    localparam logic [7:0] CMD_LOAD = 8'h55;
    localparam logic [7:0] CMD_SET = 8'h11;
    localparam logic [6:0] DAC_MAX = 7'h7F;
    localparam logic [6:0] DAC_MIN = 7'h00;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam int WRITE_MS = 11;
    localparam int WRITE_CYC = WRITE_MS * 1000 * 1000 * CLK_MHZ / 1000;
endpackage

// File: logic/bdcs_nv_if.sv
// Link between the command store and its nonvolatile write timer.
// Assumes one clock domain.
`timescale 1ns/1ps
interface bdcs_nv_if;
    logic start;
    logic busy;
    logic done;
    modport ctrl (output start, input busy, input done);
    modport timer (input start, output busy, output done);
endinterface

// File: logic/bdcs_nv_timer.sv
// Times one nonvolatile write cycle.
// Assumes start is a one-cycle pulse from the same clock.
`timescale 1ns/1ps
module bdcs_nv_timer
    import bdcs_pkg::*;
#(
    parameter int CYCLES = WRITE_CYC
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Control link
    bdcs_nv_if.timer nv
);
    typedef struct packed {
        logic [31:0] count;
        logic busy;
        logic done;
    } bdcs_tmr_t;
    bdcs_tmr_t s_r;
    bdcs_tmr_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (s_r.busy)
        begin
            if (s_r.count == 32'(CYCLES - 1))
            begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
                s_nxt.count = '0;
            end
            else
            begin
                s_nxt.count = s_r.count + 32'h1;
            end
        end
        else if (nv.start)
        begin
            s_nxt.busy = 1'b1;
            s_nxt.count = '0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign nv.busy = s_r.busy;
    assign nv.done = s_r.done;
endmodule

// File: logic/bdcs_top.sv
// Receive-only two-wire slave that adjusts and stores a 7-bit DAC code.
// Assumes open-drain bus pins sampled from outside the clock domain and a
// nonvolatile cell modelled as flip-flops with a timed write.
//
// Notes on behaviour
// - hold 7-bit DAC code, commands update it
// - nonvolatile copy rewritable without a count limit
// - requests arrive only over the two-wire bus
// - valid non-store commands set program mode
// - nonvolatile write lasts 11 ms
// - low programming supply blocks nonvolatile writes
// - answer only write address 0x2F
// - decode dec, inc, store, load, set commands
// - power-up loads code from nonvolatile copy
// - no command ack while busy or store refused
`timescale 1ns/1ps
module bdcs_top
    import bdcs_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYC,
    parameter logic [6:0] NV_INIT = DAC_MIN
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Two-wire bus
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Supply detector
    input wire logic programSupplyOk,
    // Converter side
    output logic [6:0] dacCode,
    output logic programMode,
    output logic nvBusy
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_CMD, ST_VAL, ST_ACK, ST_IGNORE
    } bdcs_state_t;

    typedef struct packed {
        logic [1:0] sclSync;
        logic [1:0] sdaSync;
        logic [1:0] supplySync;
        logic sclPrev;
        logic sdaPrev;
        bdcs_state_t state;
        bdcs_state_t after;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic ackDrive;
        logic isSet;
        logic booted;
        logic [6:0] dac;
        logic [6:0] nvCell;
        logic progMode;
        logic start;
        logic [7:0] pendCmd;
    } bdcs_st_t;

    bdcs_st_t s_r;
    bdcs_st_t s_nxt;
    bdcs_nv_if nv ();

    bdcs_nv_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .nv(nv)
    );

    logic scl;
    logic sda;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic [7:0] rxByte;
    logic cmdOk;
    logic supplyOk;

    assign scl = s_r.sclSync[1];
    assign sda = s_r.sdaSync[1];
    // Detector output is asynchronous to the logic clock
    assign supplyOk = s_r.supplySync[1];
    assign sclRise = scl && !s_r.sclPrev;
    assign sclFall = !scl && s_r.sclPrev;
    assign startCond = scl && s_r.sclPrev && s_r.sdaPrev && !sda;
    assign stopCond = scl && s_r.sclPrev && !s_r.sdaPrev && sda;
    assign rxByte = {s_r.shift[6:0], sda};

    // Store needs program mode and supply; nothing is taken while busy
    always_comb
    begin
        cmdOk = 1'b0;
        if (!nv.busy)
        begin
            unique case (rxByte)
                CMD_DEC, CMD_INC, CMD_LOAD, CMD_SET: cmdOk = 1'b1;
                CMD_STORE: cmdOk = s_r.progMode && supplyOk;
                default: cmdOk = 1'b0;
            endcase
        end
    end

    //--------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.sclSync = {s_r.sclSync[0], sclIn};
        s_nxt.sdaSync = {s_r.sdaSync[0], sdaIn};
        s_nxt.supplySync = {s_r.supplySync[0], programSupplyOk};
        s_nxt.sclPrev = scl;
        s_nxt.sdaPrev = sda;
        s_nxt.start = 1'b0;

        if (!s_r.booted)
        begin
            s_nxt.dac = s_r.nvCell;
            s_nxt.booted = 1'b1;
        end

        // Commit the store only after the timer completes
        if (nv.done)
        begin
            s_nxt.nvCell = s_r.dac;
            s_nxt.progMode = 1'b0;
        end

        if (startCond)
        begin
            s_nxt.state = ST_ADDR;
            s_nxt.bitCnt = '0;
            s_nxt.ackDrive = 1'b0;
            s_nxt.isSet = 1'b0;
        end
        else if (stopCond)
        begin
            s_nxt.state = ST_IDLE;
            s_nxt.ackDrive = 1'b0;
        end
        else
        begin
            unique case (s_r.state)
                ST_IDLE, ST_IGNORE: ;
                ST_ADDR, ST_CMD, ST_VAL:
                begin
                    if (sclRise)
                    begin
                        s_nxt.shift = rxByte;
                        s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                    end
                    if (sclRise && s_r.bitCnt == BIT_LAST)
                    begin
                        s_nxt.state = ST_ACK;
                        s_nxt.after = ST_IGNORE;
                        if (s_r.state == ST_ADDR)
                        begin
                            if (rxByte == {SLAVE_ADDR, 1'b0})
                            begin
                                s_nxt.after = ST_CMD;
                            end
                        end
                        else if (s_r.state == ST_CMD)
                        begin
                            if (cmdOk)
                            begin
                                s_nxt.after = ST_IDLE;
                                s_nxt.pendCmd = rxByte;
                                if (rxByte == CMD_SET)
                                    s_nxt.after = ST_VAL;
                            end
                        end
                        else
                        begin
                            s_nxt.after = ST_IDLE;
                            s_nxt.isSet = 1'b1;
                        end
                    end
                end
                ST_ACK:
                begin
                    // Drive ack low from the SCL fall after bit 8
                    if (sclFall && !s_r.ackDrive)
                        s_nxt.ackDrive = (s_r.after != ST_IGNORE);
                    else if (sclFall && s_r.ackDrive)
                    begin
                        s_nxt.ackDrive = 1'b0;
                        s_nxt.bitCnt = '0;
                        s_nxt.state = s_r.after;
                        if (s_r.after == ST_IDLE && s_r.isSet)
                        begin
                            s_nxt.dac = s_r.shift[6:0];
                            s_nxt.progMode = 1'b1;
                        end
                        else if (s_r.after == ST_IDLE)
                        begin
                            unique case (s_r.pendCmd)
                                CMD_DEC:
                                    if (s_r.dac != DAC_MIN)
                                        s_nxt.dac = s_r.dac - 7'h01;
                                CMD_INC:
                                    if (s_r.dac != DAC_MAX)
                                        s_nxt.dac = s_r.dac + 7'h01;
                                CMD_LOAD: s_nxt.dac = s_r.nvCell;
                                CMD_STORE: s_nxt.start = 1'b1;
                                default: ;
                            endcase
                            if (s_r.pendCmd != CMD_STORE)
                                s_nxt.progMode = 1'b1;
                        end
                    end
                    else if (sclFall)
                        s_nxt.state = s_r.after;
                end
            endcase
        end
        if (s_r.state == ST_ACK && sclFall && s_r.after == ST_IGNORE)
            s_nxt.state = ST_IGNORE;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            s_r <= '0;
            s_r.sclSync <= 2'h3;
            s_r.sdaSync <= 2'h3;
            s_r.sclPrev <= 1'b1;
            s_r.sdaPrev <= 1'b1;
            s_r.nvCell <= NV_INIT;
        end
        else
            s_r <= s_nxt;
    end

    assign nv.start = s_r.start && supplyOk;
    assign sdaOut = 1'b0;
    assign sdaOe = s_r.ackDrive;
    assign dacCode = s_r.dac;
    assign programMode = s_r.progMode;
    assign nvBusy = nv.busy;
endmodule

// File: verification/bdcs_top_properties.sv
// Port checker for the DAC command store.
// Assumes one clock domain, bound to bdcs_top.
`timescale 1ns/1ps
module bdcs_top_properties
    import bdcs_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYC
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Bus and supply
    input wire logic sclIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic programSupplyOk,
    // Outputs
    input wire logic [6:0] dacCode,
    input wire logic programMode,
    input wire logic nvBusy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    int busyCnt_r;
    always_ff @(posedge ref_clk)
        busyCnt_r <= (resetn && nvBusy) ? busyCnt_r + 1 : 0;
    sequence s_ack_hold;
        sdaOe [*3];
    endsequence
    sequence s_ack_drop;
        ##[1:5] !sdaOe;
    endsequence
    property p_ack_hold;
        $rose(sdaOe) |-> s_ack_hold;
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("ack pulse too short");
    property p_ack_drop;
        sdaOe && $fell(sclIn) |-> s_ack_drop;
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("ack not released");
    property p_open_drain;
        sdaOe |-> !sdaOut;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("data pin driven high");
    property p_ack_scl_low;
        $changed(sdaOe) |-> !sclIn;
    endproperty
    a_ack_scl_low: assert property (p_ack_scl_low)
        else $error("ack changed while clock high");
    property p_busy_len;
        $fell(nvBusy) |-> busyCnt_r == WRITE_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("write cycle length wrong");
    property p_pm_clr;
        $fell(nvBusy) |-> ##[0:2] !programMode;
    endproperty
    a_pm_clr: assert property (p_pm_clr)
        else $error("program mode kept after write");
    property p_busy_cause;
        $rose(nvBusy) |-> $past(programMode) && $past(programSupplyOk, 3);
    endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("write started without program mode or supply");
    property p_busy_dac;
        nvBusy && $past(nvBusy) |-> $stable(dacCode);
    endproperty
    a_busy_dac: assert property (p_busy_dac)
        else $error("code changed during write");
    property p_reset;
        disable iff (1'b0) !resetn |=> dacCode == 7'h00 && !programMode
            && !nvBusy && !sdaOe;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset values wrong");
endmodule

bind bdcs_top bdcs_top_properties #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (
    .ref_clk(ref_clk), .resetn(resetn), .sclIn(sclIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .programSupplyOk(programSupplyOk), .dacCode(dacCode),
    .programMode(programMode), .nvBusy(nvBusy));

// File: verification/bdcs_i2c_master.sv
// Two-wire bus master model for the DAC command store bench.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
module bdcs_i2c_master
(
    // Clock
    input wire logic clk,
    // Bus
    input wire logic sdaLine,
    output logic scl,
    output logic sdaDrv
);
    initial
    begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    // Phases of 4+ clocks stay well clear of the 2-stage sync delay
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic start();
        hold(8);
        sdaDrv = 1'b0;
        hold(8);
        scl = 1'b0;
        hold(4);
    endtask
    task automatic put_bit(input logic b, output logic s);
        sdaDrv = b;
        hold(4);
        scl = 1'b1;
        hold(4);
        s = sdaLine;
        hold(4);
        scl = 1'b0;
        hold(4);
    endtask
    // MSB first, ninth clock releases the line for the ack
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(v[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    endtask
    task automatic stop();
        sdaDrv = 1'b0;
        hold(4);
        scl = 1'b1;
        hold(8);
        sdaDrv = 1'b1;
    endtask
endmodule

// File: verification/tb_backplane_dac_command_store.sv
// Self-checking bench for the DAC command store.
// Assumes the master model and the checker compile first.
`timescale 1ns/1ps
module tb_backplane_dac_command_store;
    import bdcs_pkg::*;
    localparam int WCYC = 400;
    localparam logic [6:0] INIT = 7'h3A;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic supplyOk = 1'b1;
    logic scl, sdaDrv, sdaOut, sdaOe, programMode, nvBusy;
    logic [6:0] dacCode;
    wire logic sdaLine = sdaDrv & (sdaOe ? sdaOut : 1'b1);
    int fail_count = 0, n_checks = 0, cyc = 0, busyEnd = 0;
    int seed = 32'h52b8, mDac = INIT, mNv = INIT, mPm = 0;
    logic [7:0] ops[4] = '{CMD_DEC, CMD_INC, CMD_SET, CMD_LOAD};
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc++;
    bdcs_i2c_master m_u (.clk(ref_clk), .sdaLine(sdaLine), .scl(scl),
        .sdaDrv(sdaDrv));
    bdcs_top #(.WRITE_CYCLES(WCYC), .NV_INIT(INIT)) dut_u (
        .ref_clk(ref_clk), .resetn(resetn), .sclIn(scl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .programSupplyOk(supplyOk),
        .dacCode(dacCode), .programMode(programMode), .nvBusy(nvBusy));
    task automatic cmp(input string what, input int exp, input logic [6:0] got);
        n_checks++;
        if (got !== exp[6:0])
        begin
            fail_count++;
            $display("[FAIL] %s expected %0h got %0h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        if (fail_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic send(input logic [7:0] adr, c, v);
        logic a;
        int ok;
        ok = adr == {SLAVE_ADDR, 1'b0};
        m_u.start();
        m_u.put_byte(adr, a);
        cmp("addrAck", ok, a);
        if (ok)
        begin
            ok = c inside {CMD_DEC, CMD_INC, CMD_LOAD, CMD_SET}
                || (c == CMD_STORE && mPm && supplyOk);
            m_u.put_byte(c, a);
            if (cyc < busyEnd)
                ok = 0;
            cmp("cmdAck", ok, a);
        end
        if (ok && c == CMD_SET)
            m_u.put_byte(v, a);
        m_u.stop();
        if (ok)
        begin
            if (c != CMD_STORE)
                mPm = 1;
            case (c)
                CMD_DEC: mDac = mDac == 0 ? 0 : mDac - 1;
                CMD_INC: mDac = mDac == 127 ? 127 : mDac + 1;
                CMD_LOAD: mDac = mNv;
                CMD_SET: mDac = v[6:0];
                default:
                begin
                    mNv = mDac;
                    busyEnd = cyc + WCYC;
                end
            endcase
        end
        cmp("dacCode", mDac, dacCode);
        cmp("programMode", mPm, programMode);
        cmp("nvBusy", cyc < busyEnd, nvBusy);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] r;
        repeat (12) @(posedge ref_clk);
        #1 resetn = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        cmp("dacCode", INIT, dacCode);
        cmp("programMode", 0, programMode);
        send(8'h5E, CMD_STORE, 0);
        send(8'h5C, CMD_INC, 0);
        send(8'h5F, CMD_INC, 0);
        send(8'h5E, 8'h12, 0);
        send(8'h5E, CMD_SET, 8'hFF);
        send(8'h5E, CMD_INC, 0);
        send(8'h5E, CMD_SET, 8'h80);
        send(8'h5E, CMD_DEC, 0);
        repeat (6)
        begin
            r = $random(seed);
            send(8'h5E, ops[r[1:0]], r[15:8]);
        end
        repeat (2)
        begin
            r = $random(seed);
            send(8'h5E, CMD_SET, r[7:0]);
            supplyOk = 1'b0;
            send(8'h5E, CMD_STORE, 0);
            supplyOk = 1'b1;
            send(8'h5E, CMD_STORE, 0);
            send(8'h5E, CMD_LOAD, 0);
            repeat (100) @(posedge ref_clk);
            #1;
            mPm = 0;
            cmp("programMode", mPm, programMode);
            cmp("nvBusy", 0, nvBusy);
            send(8'h5E, CMD_INC, 0);
            send(8'h5E, CMD_LOAD, 0);
        end
        complete_run();
    end
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        fail_count++;
        complete_run();
    end
endmodule
